// ---- common/nv_seq_pkg.sv ----
// shared constants and types of the store/recall sequencer
// assumes a single 50 MHz clock; all times are printed figures in ns
package nv_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned T_FA_LOW_NS          = 40_000_000;
  localparam int unsigned T_FA_NS              = 20_000_000;
  localparam int unsigned T_STORE_NS           = 8_000_000;
  localparam int unsigned T_DELAY_NS           = 25;
  localparam int unsigned T_RESUME_NS          = 5_000;
  localparam int unsigned T_HIGH_ACTIVE_NS     = 500;
  localparam int unsigned T_WAKE_LOW_NS        = 40_000_000;
  localparam int unsigned T_WAKE_NS            = 20_000_000;
  localparam int unsigned T_SLEEP_NS           = 8_000_000;
  localparam int unsigned T_STANDBY_NS         = 100_000;
  localparam int unsigned T_RECALL_NS          = 600_000;
  localparam int unsigned T_SOFT_SEQ_NS        = 500_000;
  localparam int unsigned HW_SAVE_PULSE_MIN_NS = 15;

  // longest times round down, never below one cycle
  function automatic int unsigned max_cycles(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction : max_cycles

  typedef enum logic [3:0] {
    ST_OFF     = 4'h0,
    ST_PUREC   = 4'h1,
    ST_IDLE    = 4'h3,
    ST_HOLD    = 4'h2,
    ST_STORE   = 4'h6,
    ST_HIGHDRV = 4'h4,
    ST_RECALL  = 4'hC,
    ST_SLPENT  = 4'hD,
    ST_SLEEP   = 4'hF,
    ST_WAKE    = 4'hE
  } state_t;

  typedef enum logic [1:0] {
    OP_STORE  = 2'h0,
    OP_RECALL = 2'h1,
    OP_SLEEP  = 2'h2
  } cmd_op_t;

  typedef struct packed {
    logic    valid;
    cmd_op_t op;
  } cmd_t;

  typedef struct packed {
    logic req;
    logic write;
  } mem_req_t;

  typedef struct packed {
    logic busy;
    logic storing;
    logic recalling;
    logic sleeping;
    logic standby;
    logic ioLock;
  } status_t;
endpackage : nv_seq_pkg

// ---- src/nv_store_recall_sequencer.sv ----
// sequencer for saving the array to nonvolatile cells and restoring it
// assumes the command decoder and array share clk; vccOk, csN and the
// save pin arrive asynchronously and are synchronised here
`timescale 1ns/1ps

// What this block does
// (RQ1) skip automatic or pin save when clean
// (RQ2) finish in-progress write 25 ns, then block
// (RQ3) ignore accesses during save, restore, low supply
// (RQ4) power-up restore within 40/20 ms
// (RQ5) act on soft command within 500 us
// (RQ6) lock serial I/O during command save/restore
// (RQ7) host holds save pin low 15 ns
// (RQ8) array disabled while save pin low
// (RQ9) no pin drive unless write latch set
// (RQ10) resume access within 5 us of release
// (RQ11) active high drive lasts at most 500 ns
// (RQ12) enter sleep within 8 ms
// (RQ13) wake from sleep within 40/20 ms
// (RQ14) enter standby within 100 us of deselect
// (RQ15) timer-counted durations, busy shown, busy requests rejected
module nv_store_recall_sequencer
  import nv_seq_pkg::*;
#(
  parameter bit          LOW_VOLT_PART = 1'b0,
  parameter int unsigned TW            = 22,
  parameter int unsigned FA_CYC        = max_cycles(LOW_VOLT_PART ? T_FA_LOW_NS : T_FA_NS),
  parameter int unsigned STORE_CYC     = max_cycles(T_STORE_NS),
  parameter int unsigned RECALL_CYC    = max_cycles(T_RECALL_NS),
  parameter int unsigned SLEEP_CYC     = max_cycles(T_SLEEP_NS),
  parameter int unsigned WAKE_CYC      = max_cycles(LOW_VOLT_PART ? T_WAKE_LOW_NS : T_WAKE_NS),
  parameter int unsigned STANDBY_CYC   = max_cycles(T_STANDBY_NS)
) (
  input  wire logic               clk,         // 50 MHz clock
  input  wire logic               reset_n,     // async reset, active low
  input  wire logic               clkEn,       // freezes all state when low
  input  wire logic               vccOk,       // supply above trigger level (async)
  input  wire logic               csN,         // serial chip select, active low (async)
  input  wire logic               hwSavePinIn, // hw_save_pin_n pad level (async)
  output logic                    hwSavePinOut,// hw_save_pin_n drive value
  output logic                    hwSavePinOe, // hw_save_pin_n drive enable
  input  wire nv_seq_pkg::cmd_t   cmd,         // soft-sequence command
  output logic                    cmdReject,   // command refused while busy
  input  wire nv_seq_pkg::mem_req_t memReq,    // array access request
  output logic                    memGrant,    // access taken this cycle
  output logic                    arrayEn,     // array enabled
  output nv_seq_pkg::status_t     status       // sequencer status
);
  import nv_seq_pkg::*;

  localparam int unsigned DELAY_CYC  = max_cycles(T_DELAY_NS);
  localparam int unsigned HIGH_CYC   = max_cycles(T_HIGH_ACTIVE_NS);
  localparam int unsigned RESUME_CYC = max_cycles(T_RESUME_NS);
  localparam int unsigned SS_CYC     = max_cycles(T_SOFT_SEQ_NS);

  if (FA_CYC >= (1 << TW) || WAKE_CYC >= (1 << TW) || STORE_CYC >= (1 << TW) ||
      STANDBY_CYC >= (1 << TW) || FA_CYC == 0 || STORE_CYC == 0) begin : g_chk
    $error("timer width too small for the configured durations");
  end

  // two-flop synchronisers; only the second stage is read
  logic [2:0] syncA_q, syncA_d, syncB_q, syncB_d;
  logic       vccOkS, csHighS, pinLowS;

  always_comb begin
    syncA_d = {vccOk, csN, ~hwSavePinIn};
    syncB_d = syncA_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 3'h2;
      syncB_q <= 3'h2;
    end else if (clkEn) begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
    end
  end

  assign {vccOkS, csHighS, pinLowS} = syncB_q;

  state_t        state_q, state_d;
  logic [TW-1:0] timer_q, timer_d, loadVal, highCnt_q, highCnt_d;
  logic          dirty_q, dirty_d, drive_q, drive_d, byCmd_q, byCmd_d;
  logic          pinPrev_q, pinPrev_d, standby_q, standby_d;
  logic          tDone, idleOpen, pinFall;

  assign tDone    = (timer_q == '0);
  assign pinFall  = pinLowS && !pinPrev_q;
  assign idleOpen = (state_q == ST_IDLE) && vccOkS && !pinLowS;
  // the hold window still grants any write request while the pin is high, reads are not taken
  assign memGrant = memReq.req && clkEn &&
                    (idleOpen || (state_q == ST_HOLD && memReq.write && !pinLowS)); // RQ2 RQ3 RQ8
  assign cmdReject = cmd.valid && clkEn && !idleOpen; // RQ15

  always_comb begin
    state_d = state_q;
    loadVal = '0;
    drive_d = drive_q;
    byCmd_d = byCmd_q;
    dirty_d = dirty_q;
    case (state_q)
      ST_OFF: begin
        if (vccOkS) begin
          state_d = ST_PUREC;
          loadVal = TW'(FA_CYC - 1); // RQ4
        end
      end
      ST_PUREC: begin
        if (!vccOkS) state_d = ST_OFF;
        else if (tDone) begin
          state_d = ST_IDLE;
          dirty_d = 1'b0;
        end
      end
      ST_IDLE: begin
        if (!vccOkS || pinFall) begin
          // a clean array needs no save at all
          if (dirty_q) begin // RQ1
            state_d = ST_HOLD;
            loadVal = TW'(DELAY_CYC - 1); // RQ2
            byCmd_d = 1'b0;
          end else if (!vccOkS) begin
            state_d = ST_OFF;
          end
        end else if (cmd.valid) begin // RQ5
          byCmd_d = 1'b1;
          case (cmd.op)
            OP_STORE: begin
              state_d = ST_STORE;
              loadVal = TW'(STORE_CYC - 1);
              drive_d = dirty_q; // RQ9
            end
            OP_RECALL: begin
              state_d = ST_RECALL;
              loadVal = TW'(RECALL_CYC - 1);
            end
            OP_SLEEP: begin
              state_d = ST_SLPENT;
              loadVal = TW'(SLEEP_CYC - 1); // RQ12
            end
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_HOLD: begin
        if (tDone) begin
          state_d = ST_STORE;
          loadVal = TW'(STORE_CYC - 1);
          drive_d = 1'b1; // RQ9
        end
      end
      ST_STORE: begin
        if (tDone) begin // RQ15
          dirty_d = 1'b0;
          if (drive_q) begin
            state_d = ST_HIGHDRV;
            loadVal = TW'(HIGH_CYC - 1); // RQ11
          end else begin
            state_d = vccOkS ? ST_IDLE : ST_OFF;
          end
        end
      end
      ST_HIGHDRV: begin
        if (tDone) begin
          drive_d = 1'b0;
          state_d = vccOkS ? ST_IDLE : ST_OFF; // RQ10
        end
      end
      ST_RECALL: begin
        if (!vccOkS) state_d = ST_OFF;
        else if (tDone) begin
          state_d = ST_IDLE;
          dirty_d = 1'b0;
        end
      end
      ST_SLPENT: begin
        if (tDone) state_d = ST_SLEEP; // RQ12
      end
      ST_SLEEP: begin
        if (!vccOkS) state_d = ST_OFF;
        else if (!csHighS) begin
          state_d = ST_WAKE;
          loadVal = TW'(WAKE_CYC - 1); // RQ13
        end
      end
      ST_WAKE: begin
        if (tDone) state_d = ST_IDLE; // RQ13
      end
      default: state_d = ST_OFF;
    endcase
    // a write taken in this same cycle still marks the array dirty
    if (memGrant && memReq.write) dirty_d = 1'b1;
    timer_d   = (state_d != state_q) ? loadVal : (tDone ? timer_q : timer_q - 1'b1);
    pinPrev_d = pinLowS;
    standby_d = csHighS && (state_q == ST_IDLE); // RQ14
    highCnt_d = (hwSavePinOe && hwSavePinOut) ? highCnt_q + 1'b1 : '0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= ST_OFF;
      timer_q   <= '0;
      dirty_q   <= 1'b0;
      drive_q   <= 1'b0;
      byCmd_q   <= 1'b0;
      pinPrev_q <= 1'b0;
      standby_q <= 1'b0;
      highCnt_q <= '0;
    end else if (clkEn) begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      dirty_q   <= dirty_d;
      drive_q   <= drive_d;
      byCmd_q   <= byCmd_d;
      pinPrev_q <= pinPrev_d;
      standby_q <= standby_d;
      highCnt_q <= highCnt_d;
    end
  end

  // low while storing, then a short active high before release
  assign hwSavePinOe  = drive_q && (state_q == ST_STORE || state_q == ST_HIGHDRV); // RQ9 RQ11
  assign hwSavePinOut = (state_q == ST_HIGHDRV);
  assign arrayEn      = (state_q == ST_IDLE || state_q == ST_HOLD) && !pinLowS; // RQ8

  always_comb begin
    status.busy      = (state_q != ST_IDLE); // RQ15
    status.storing   = (state_q == ST_STORE);
    status.recalling = (state_q == ST_RECALL || state_q == ST_PUREC);
    status.sleeping  = (state_q == ST_SLEEP);
    status.standby   = standby_q;
    status.ioLock    = byCmd_q && (state_q == ST_STORE || state_q == ST_RECALL); // RQ6
  end

  // checks
  sequence s_saveStart;
    state_q == ST_HOLD ##1 state_q == ST_STORE;
  endsequence

  property p_cleanSkip;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && state_q == ST_IDLE && !vccOkS && !dirty_q) |=> state_q == ST_OFF;
  endproperty
  a_cleanSkip: assert property (p_cleanSkip) else $error("clean array was saved"); // RQ1
  property p_holdThenStore;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && state_q == ST_IDLE && (!vccOkS || pinFall) && dirty_q) ##1 clkEn |-> s_saveStart;
  endproperty
  a_holdThenStore: assert property (p_holdThenStore) else $error("write hold not one cycle"); // RQ2
  // the one-cycle hold window may still finish a started write
  property p_noAccessBusy;
    @(posedge clk) disable iff (!reset_n)
      (state_q inside {ST_STORE, ST_RECALL, ST_PUREC} || (!vccOkS && state_q != ST_HOLD))
        |-> !memGrant;
  endproperty
  a_noAccessBusy: assert property (p_noAccessBusy) else $error("access granted while busy"); // RQ3
  property p_restoreEnds;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && state_q == ST_PUREC && tDone && vccOkS) |=> state_q == ST_IDLE;
  endproperty
  a_restoreEnds: assert property (p_restoreEnds) else $error("restore overran"); // RQ4
  property p_cmdActed;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && idleOpen && cmd.valid) |=> (state_q != ST_IDLE && byCmd_q);
  endproperty
  a_cmdActed: assert property (p_cmdActed) else $error("command not acted on"); // RQ5
  property p_ioLock;
    @(posedge clk) disable iff (!reset_n)
      (byCmd_q && state_q == ST_RECALL) |-> status.ioLock && status.busy;
  endproperty
  a_ioLock: assert property (p_ioLock) else $error("serial I/O not locked"); // RQ6
  property p_pinDisables;
    @(posedge clk) disable iff (!reset_n)
      pinLowS |-> !arrayEn && !memGrant;
  endproperty
  a_pinDisables: assert property (p_pinDisables) else $error("array on while pin low"); // RQ8
  property p_noDriveClean;
    @(posedge clk) disable iff (!reset_n)
      $rose(hwSavePinOe) |-> $past(dirty_q);
  endproperty
  a_noDriveClean: assert property (p_noDriveClean) else $error("pin driven without latch"); // RQ9
  property p_highShort;
    @(posedge clk) disable iff (!reset_n)
      (hwSavePinOe && hwSavePinOut) |-> highCnt_q < TW'(HIGH_CYC);
  endproperty
  a_highShort: assert property (p_highShort) else $error("active high drive too long"); // RQ11

  property p_wakeEnds;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && state_q == ST_WAKE && tDone) |=> state_q == ST_IDLE;
  endproperty
  a_wakeEnds: assert property (p_wakeEnds) else $error("wake overran"); // RQ13

  property p_standby;
    @(posedge clk) disable iff (!reset_n)
      (clkEn && csHighS && state_q == ST_IDLE) |=> status.standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered"); // RQ14
endmodule : nv_store_recall_sequencer

// ---- sim/pin_host_model.sv ----
// host side of the save pin: host pull-down plus the pad pull-up
// assumes the device drive value and enable come straight from its ports
`timescale 1ns/1ps
module pin_host_model (
  input  wire logic hostLow,  // host pulls the pin low
  input  wire logic devOe,    // device drive enable
  input  wire logic devOut,   // device drive value
  output logic      padLevel  // resolved pad level
);
  // a driving device wins; a released pad floats up, never holds its last value
  always_comb begin
    if (devOe) begin
      padLevel = devOut;
    end else if (hostLow) begin
      padLevel = 1'b0;
    end else begin
      padLevel = 1'b1;
    end
  end
endmodule : pin_host_model

// ---- sim/tb.sv ----
// self-checking bench for the store/recall sequencer
// assumes short timer parameters; the host owns cmd, memReq, csN and vccOk
`timescale 1ns/1ps
module tb;
  import nv_seq_pkg::*;
  localparam int FA = 16, SC = 20, RC = 12, SL = 10, WK = 14;
  logic clk, reset_n, vccOk, csN, hostLow, pad, pinOut, pinOe, cmdReject, memGrant, arrayEn;
  cmd_t     cmd;
  mem_req_t memReq;
  status_t  status;
  logic     clkEn;
  int       miscompares, num_checks, cyc, n;

  nv_store_recall_sequencer #(.FA_CYC(FA), .STORE_CYC(SC), .RECALL_CYC(RC), .SLEEP_CYC(SL),
    .WAKE_CYC(WK), .STANDBY_CYC(8)) u_dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .vccOk(vccOk), .csN(csN), .hwSavePinIn(pad), .hwSavePinOut(pinOut),
    .hwSavePinOe(pinOe), .cmd(cmd), .cmdReject(cmdReject), .memReq(memReq),
    .memGrant(memGrant), .arrayEn(arrayEn), .status(status));
  pin_host_model u_host (.hostLow(hostLow), .devOe(pinOe), .devOut(pinOut), .padLevel(pad));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    num_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  function automatic logic pick(input int sel);
    case (sel)
      0: return status.busy;
      1: return status.sleeping;
      2: return status.standby;
      3: return pinOe;
      default: return arrayEn;
    endcase
  endfunction : pick

  // bounded wait, counted in cycles, for one status bit, pinOe or arrayEn to reach a level
  task automatic wait_for(input int sel, input logic v, input int lim, output int k);
    k = 0;
    while (pick(sel) !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_for

  task automatic issue(input cmd_op_t op);
    @(posedge clk) cmd <= '{valid: 1'b1, op: op};
    @(posedge clk) cmd <= '0;
    @(negedge clk);
  endtask : issue

  task automatic access(input logic wr, input logic exp, input string nm);
    @(posedge clk) memReq <= '{req: 1'b1, write: wr};
    @(negedge clk) chk(nm, exp, memGrant);
    @(posedge clk) memReq <= '0;
  endtask : access

  task automatic t_powerup;
    wait_for(0, 1'b0, 200, n);
    chk_rng("restore cycles", FA, FA + 4, n);
    access(1'b0, 1'b1, "read after restore");
  endtask : t_powerup

  task automatic t_soft(input cmd_op_t op, input int len);
    issue(op);
    chk("busy", 1'b1, status.busy);
    chk("ioLock", 1'b1, status.ioLock);
    chk("phase flag", 1'b1, op == OP_STORE ? status.storing : status.recalling);
    @(posedge clk) cmd <= '{valid: 1'b1, op: OP_RECALL};
    @(negedge clk) chk("reject", 1'b1, cmdReject);
    @(posedge clk) cmd <= '0;
    access(1'b1, 1'b0, "grant while busy");
    wait_for(0, 1'b0, 100, n);
    chk_rng("soft op cycles", len - 4, len, n);
  endtask : t_soft

  task automatic t_pin(input logic dirty);
    if (dirty) access(1'b1, 1'b1, "write grant");
    @(posedge clk) hostLow <= 1'b1;
    wait_for(3, 1'b1, 6, n);
    chk("pin driven", dirty, pinOe);
    chk("array off", 1'b0, arrayEn);
    access(1'b1, 1'b0, "grant pin low");
    @(posedge clk) hostLow <= 1'b0;
    if (dirty) begin
      chk("store low", 1'b0, pinOut);
      wait_for(3, 1'b0, 100, n);
      chk_rng("store plus high drive", SC - 4, SC + 25, n);
    end
    wait_for(4, 1'b1, 6, n);
    chk_rng("resume cycles", 0, 5, n);
    chk("no drive idle", 1'b0, pinOe);
    chk("pad pulled up", 1'b1, pad);
  endtask : t_pin

  task automatic t_sleep;
    @(posedge clk) csN <= 1'b1;
    wait_for(2, 1'b1, 20, n);
    chk_rng("standby cycles", 1, 6, n);
    issue(OP_SLEEP);
    wait_for(1, 1'b1, 40, n);
    chk_rng("sleep entry", 0, SL + 2, n);
    @(posedge clk) csN <= 1'b0;
    wait_for(0, 1'b0, 60, n);
    chk_rng("wake cycles", 1, WK + 5, n);
    chk("awake", 1'b0, status.sleeping);
  endtask : t_sleep

  task automatic t_vcc;
    @(posedge clk) vccOk <= 1'b0;
    repeat (4) @(negedge clk);
    chk("no store clean", 1'b0, pinOe);
    access(1'b0, 1'b0, "grant low supply");
    @(posedge clk) vccOk <= 1'b1;
    @(negedge clk);
    t_powerup;
  endtask : t_vcc

  // five frozen edges stretch a recall by five cycles
  task automatic t_freeze;
    issue(OP_RECALL);
    @(posedge clk) clkEn <= 1'b0;
    repeat (5) @(negedge clk);
    chk("frozen busy", 1'b1, status.busy);
    @(posedge clk) clkEn <= 1'b1;
    wait_for(0, 1'b0, 40, n);
    chk_rng("frozen recall cycles", RC - 2, RC, n);
  endtask : t_freeze

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    reset_n = 1'b0;
    vccOk = 1'b1;
    csN = 1'b0;
    hostLow = 1'b0;
    clkEn = 1'b1;
    cmd = '0;
    memReq = '0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    t_powerup;
    t_soft(OP_RECALL, RC);
    t_soft(OP_STORE, SC);
    t_pin(1'b0);
    t_pin(1'b1);
    t_sleep;
    t_vcc;
    t_freeze;
    end_sim();
  end
endmodule : tb
